// ===== abu_chk.sv
`timescale 1ns/10ps
`include "brk_consts.vh"
// ****************************************
// port checker
// ****************************************
module abu_chk (
    input wire REF_CLK,
    input wire RESETN,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [31:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [3:0] PSTRB,
    input wire PREADY,
    input wire PSLVERR,
    input wire [15:0] CPU_ADDR,
    input wire CPU_FETCH,
    input wire CPU_RTI_DONE,
    input wire MONITOR_MODE,
    input wire BREAK_CLEAR_FLAG_ENABLE,
    input wire BREAKPOINT_REQUEST,
    input wire BREAK_STATE,
    input wire TAKE_SWI_NOW,
    input wire [15:0] BREAK_VECTOR,
    input wire TIMER_HALT,
    input wire WATCHDOG_DISABLE,
    input wire FLAG_CLEAR_ALLOW
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    reg [15:0] ba;
    reg en;
    wire wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && !PSLVERR;
    wire wsc = wr && PADDR[17:2] == `IDX_BREAK_STATUS_CONTROL;
    // shadow of break address and enable, so matches can be predicted
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            ba <= 16'h0;
            en <= 1'b0;
        end else if (wr) begin
            if (PADDR[17:2] == `IDX_BREAK_ADDRESS_HIGH) ba[15:8] <= PWDATA[7:0];
            if (PADDR[17:2] == `IDX_BREAK_ADDRESS_LOW) ba[7:0] <= PWDATA[7:0];
            if (wsc) en <= PWDATA[7];
        end
    end
    match_req_a: assert property (CPU_FETCH && en && CPU_ADDR == ba |=> BREAKPOINT_REQUEST)
        else $error("match gave no request");
    swi_req_a: assert property (TAKE_SWI_NOW |-> BREAKPOINT_REQUEST)
        else $error("swi without request");
    vec_mon_a: assert property (MONITOR_MODE[*2] |-> BREAK_VECTOR == 16'hfefc)
        else $error("monitor vector wrong");
    vec_norm_a: assert property ((!MONITOR_MODE)[*2] |-> BREAK_VECTOR == 16'hfffc)
        else $error("normal vector wrong");
    rti_end_a: assert property (CPU_RTI_DONE && BREAK_STATE |-> ##[1:2] !BREAK_STATE)
        else $error("break not ended");
    timer_halt_a: assert property (BREAK_STATE == TIMER_HALT)
        else $error("timer halt differs");
    wdog_off_a: assert property ((!BREAK_STATE)[*2] |-> !WATCHDOG_DISABLE)
        else $error("watchdog off outside break");
    flag_gate_a: assert property ((BREAK_STATE && !BREAK_CLEAR_FLAG_ENABLE)[*2] |-> !FLAG_CLEAR_ALLOW)
        else $error("flag clear not gated");
    apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready");
    req_hold_a: assert property (BREAKPOINT_REQUEST && !wsc |=> BREAKPOINT_REQUEST)
        else $error("request dropped");
    cover property (TAKE_SWI_NOW);
    cover property (CPU_RTI_DONE && BREAK_STATE);
    cover property (PSLVERR);
endmodule // abu_chk
bind address_breakpoint_unit abu_chk u_chk (.*);

// ===== abu_cpu_model.sv
`timescale 1ns/10ps
// ****************************************
// cpu partner: free fetches, commanded probes
// ****************************************
module abu_cpu_model (
    input wire clk,
    input wire rstn,
    input wire [1:0] cmd,
    input wire [15:0] tgt,
    output reg [15:0] addr,
    output reg fetch,
    output reg last,
    output reg return_from_interrupt_instruction
);
    reg [14:0] pc;
    // free fetches stay in the other half of the map, so they never hit
    always @(posedge clk) begin
        return_from_interrupt_instruction <= (cmd == 2'd3);
        pc <= pc + 15'h1;
        addr <= (cmd[1] ^ cmd[0]) ? tgt : {~tgt[15], pc};
        fetch <= (cmd != 2'd2);
        last <= cmd[0] | pc[0];
        if (!rstn) begin
            pc <= 15'h0;
            return_from_interrupt_instruction <= 1'b0;
        end
    end
endmodule // abu_cpu_model

// ===== address_breakpoint_unit.v
`timescale 1ns/10ps
`include "brk_consts.vh"
module address_breakpoint_unit (
    input wire REF_CLK,
    input wire RESETN,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [31:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [3:0] PSTRB,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire [15:0] CPU_ADDR,
    input wire CPU_FETCH,
    input wire CPU_LAST_CYCLE,
    input wire CPU_RTI_DONE,
    input wire MONITOR_MODE,
    input wire RESET_PIN_HIGH_VOLTAGE,
    input wire BREAK_CLEAR_FLAG_ENABLE,
    output reg BREAKPOINT_REQUEST,
    output reg BREAK_STATE,
    output reg TAKE_SWI_NOW,
    output reg [15:0] BREAK_VECTOR,
    output reg TIMER_HALT,
    output reg WATCHDOG_DISABLE,
    output reg FLAG_CLEAR_ALLOW,
    output reg IRQ
);
    // ****************************************
    // state
    // ****************************************
    reg [7:0] break_address_high;
    reg [7:0] break_address_low;
    reg break_enable_bit;
    reg break_active_bit;
    reg [2:0] irq_status;
    reg [2:0] irq_mask;
    reg in_break;
    reg pending;
    wire hv_sync;
    wire [15:0] break_address;
    wire addr_match;
    wire wr_phase;
    wire rd_phase;
    wire [15:0] idx;
    wire addr_ok;
    wire soft_break;
    wire break_end;
    reg [7:0] next_rdata;
    reg [2:0] next_status;
    wire wr_high;
    wire wr_low;
    wire wr_control;
    wire wr_status;
    wire wr_mask;
    wire clear_active;
    reg next_request;
    reg [1:0] seq_state;
    reg [1:0] next_seq_state;
    reg next_swi;

    // break sequencer states; in_break and pending are decoded from them
    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT_END = 2'b01;
    localparam ST_IN_BREAK = 2'b10;

    // map a byte address to a register index; aligned words only
    function [15:0] reg_index;
        input [31:0] a;
        begin
            reg_index = a[17:2];
        end
    endfunction

    // true when the bus writes the given register index in this cycle
    function wr_hit;
        input [15:0] target;
        input [15:0] index;
        input phase;
        begin
            wr_hit = phase && (index == target);
        end
    endfunction

    // reset pin voltage detect arrives from the pad, so it is resynchronised
    brk_pin_sync u_hv_sync (
        .REF_CLK(REF_CLK),
        .RESETN(RESETN),
        .din(RESET_PIN_HIGH_VOLTAGE),
        .dout(hv_sync)
    );

    // ****************************************
    // bus decode
    // ****************************************
    assign idx = reg_index(PADDR);
    assign addr_ok = (PADDR[1:0] == 2'h0) && (PADDR[31:18] == 14'h0) &&
        ((idx == `IDX_BREAK_ADDRESS_HIGH) || (idx == `IDX_BREAK_ADDRESS_LOW) ||
        (idx == `IDX_BREAK_STATUS_CONTROL) || (idx == `IDX_IRQ_STATUS) ||
        (idx == `IDX_IRQ_MASK) || (idx == `IDX_CPU_STATUS));
    // writes land at the access phase; no wait states
    assign wr_phase = PSEL && PENABLE && PWRITE && addr_ok && PSTRB[0];
    assign rd_phase = PSEL && !PENABLE && !PWRITE;
    // one strobe per register keeps the write decode in a single place
    assign wr_high = wr_hit(`IDX_BREAK_ADDRESS_HIGH, idx, wr_phase);
    assign wr_low = wr_hit(`IDX_BREAK_ADDRESS_LOW, idx, wr_phase);
    assign wr_control = wr_hit(`IDX_BREAK_STATUS_CONTROL, idx, wr_phase);
    assign wr_status = wr_hit(`IDX_IRQ_STATUS, idx, wr_phase);
    assign wr_mask = wr_hit(`IDX_IRQ_MASK, idx, wr_phase);
    // a write of zero to the active bit drops the request unless a match lands
    assign clear_active = wr_control && !PWDATA[`BIT_BREAK_ACTIVE] && !addr_match;

    // ****************************************
    // match logic
    // ****************************************
    assign break_address = {break_address_high, break_address_low};
    // compare only fetch addresses so data traffic never breaks
    assign addr_match = break_enable_bit && CPU_FETCH && (CPU_ADDR == break_address);
    assign soft_break = wr_control && PWDATA[`BIT_BREAK_ACTIVE];
    assign break_end = in_break && CPU_RTI_DONE;

    // read mux, sampled in the setup cycle so data stands in the access phase
    always @* begin
        next_rdata = `RST_BYTE;
        case (idx)
            `IDX_BREAK_ADDRESS_HIGH: next_rdata = break_address_high;
            `IDX_BREAK_ADDRESS_LOW: next_rdata = break_address_low;
            `IDX_BREAK_STATUS_CONTROL: next_rdata = {break_enable_bit, break_active_bit, 6'h00};
            `IDX_IRQ_STATUS: next_rdata = {5'h00, irq_status};
            `IDX_IRQ_MASK: next_rdata = {5'h00, irq_mask};
            `IDX_CPU_STATUS: next_rdata = {6'h00, pending, in_break};
            default: next_rdata = `RST_BYTE;
        endcase
    end

    // sticky events: a set in the same cycle as a write-one clear wins
    always @* begin
        next_status = irq_status;
        if (wr_status) begin
            next_status = irq_status & ~PWDATA[2:0];
        end
        if (addr_match) begin
            next_status[`BIT_IRQ_ADDR_MATCH] = 1'b1;
        end
        if (soft_break) begin
            next_status[`BIT_IRQ_SOFT_BREAK] = 1'b1;
        end
        if (break_end) begin
            next_status[`BIT_IRQ_BREAK_END] = 1'b1;
        end
    end

    // ****************************************
    // registers and bus answer
    // ****************************************
    // address bytes stay writable in break so a debugger can move the break
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            break_address_high <= `RST_BYTE;
            break_address_low <= `RST_BYTE;
        end else begin
            if (wr_high) begin
                break_address_high <= PWDATA[7:0];
            end
            if (wr_low) begin
                break_address_low <= PWDATA[7:0];
            end
        end
    end

    // enable follows software only; active is set by a match as well
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            break_enable_bit <= 1'b0;
            break_active_bit <= 1'b0;
        end else begin
            if (wr_control) begin
                break_enable_bit <= PWDATA[`BIT_BREAK_ENABLE];
            end
            // a match sets active and wins over a same-cycle software clear
            if (addr_match) begin
                break_active_bit <= 1'b1;
            end else if (wr_control) begin
                break_active_bit <= PWDATA[`BIT_BREAK_ACTIVE];
            end
        end
    end

    // interrupt status and mask
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            irq_status <= `RST_IRQ;
            irq_mask <= `RST_IRQ;
        end else begin
            irq_status <= next_status;
            if (wr_mask) begin
                irq_mask <= PWDATA[2:0];
            end
        end
    end

    // ready one cycle after setup, so the access phase never waits
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !addr_ok;
            if (rd_phase) begin
                PRDATA <= {24'h000000, next_rdata};
            end
        end
    end

    // ****************************************
    // break sequencing toward the CPU
    // ****************************************
    // waits for instruction end; a match on the final cycle goes at once
    always @* begin
        next_seq_state = seq_state;
        next_swi = 1'b0;
        case (seq_state)
            ST_IDLE: begin
                if (addr_match || soft_break) begin
                    if (CPU_LAST_CYCLE) begin
                        next_seq_state = ST_IN_BREAK;
                        next_swi = 1'b1;
                    end else begin
                        next_seq_state = ST_WAIT_END;
                    end
                end
            end
            ST_WAIT_END: begin
                if (CPU_LAST_CYCLE) begin
                    next_seq_state = ST_IN_BREAK;
                    next_swi = 1'b1;
                end
            end
            ST_IN_BREAK: begin
                // new breaks are ignored until the return ends this one
                if (CPU_RTI_DONE) begin
                    next_seq_state = ST_IDLE;
                end
            end
            default: begin
                next_seq_state = ST_IDLE;
            end
        endcase
    end

    // state decode seen by the status read and the outputs
    always @* begin
        in_break = (seq_state == ST_IN_BREAK);
        pending = (seq_state == ST_WAIT_END);
    end

    // sequencer register and the one-cycle swi pulse
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            seq_state <= ST_IDLE;
            TAKE_SWI_NOW <= 1'b0;
        end else begin
            seq_state <= next_seq_state;
            TAKE_SWI_NOW <= next_swi;
        end
    end

    // the request follows the active bit; a match or soft write raises it at once
    always @* begin
        next_request = (break_active_bit || addr_match || soft_break) && !clear_active;
    end

    // ****************************************
    // outputs to integration unit and peripherals
    // ****************************************
    // request and break state toward the integration unit
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            BREAKPOINT_REQUEST <= 1'b0;
            BREAK_STATE <= 1'b0;
        end else begin
            BREAKPOINT_REQUEST <= next_request;
            BREAK_STATE <= in_break;
        end
    end

    // vector tracks monitor mode every cycle, so it is ready when the swi is taken
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            BREAK_VECTOR <= `VEC_BREAK_NORMAL;
        end else begin
            BREAK_VECTOR <= MONITOR_MODE ? `VEC_BREAK_MONITOR : `VEC_BREAK_NORMAL;
        end
    end

    // peripheral gates; the watchdog stays on unless in break with the high voltage present
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            TIMER_HALT <= 1'b0;
            WATCHDOG_DISABLE <= 1'b0;
            FLAG_CLEAR_ALLOW <= 1'b1;
        end else begin
            TIMER_HALT <= in_break;
            WATCHDOG_DISABLE <= in_break && hv_sync;
            FLAG_CLEAR_ALLOW <= !in_break || BREAK_CLEAR_FLAG_ENABLE;
        end
    end

    // level interrupt from the next status, so a fresh event costs no extra cycle
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(next_status & irq_mask);
        end
    end
endmodule // address_breakpoint_unit

// ===== address_breakpoint_unit_tb.sv
`timescale 1ns/10ps
`include "brk_consts.vh"
// ****************************************
// bench top
// ****************************************
module address_breakpoint_unit_tb;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg psel = 1'b0;
    reg pen = 1'b0;
    reg pwr = 1'b0;
    reg [31:0] pa = 32'h0;
    reg [31:0] pwd = 32'h0;
    reg mon = 1'b0;
    reg hv = 1'b0;
    reg break_clear_flag_enable = 1'b0;
    reg [1:0] cmd = 2'd0;
    reg [15:0] tgt = 16'h0;
    wire [31:0] prd;
    wire [15:0] vec, ca;
    wire prdy, perr, req, brk, software_interrupt_instruction, halt, wdd, fca, irq, cf, cl, crti;
    integer seed = 32'h99b0e263;
    integer miscompares = 0;
    integer n_compared = 0;
    integer cyc = 0;
    reg [32:0] expq[$];
    always #4 clk = ~clk;
    address_breakpoint_unit DUT (.REF_CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(4'hf), .PRDATA(prd), .PREADY(prdy),
        .PSLVERR(perr), .CPU_ADDR(ca), .CPU_FETCH(cf), .CPU_LAST_CYCLE(cl),
        .CPU_RTI_DONE(crti), .MONITOR_MODE(mon), .RESET_PIN_HIGH_VOLTAGE(hv),
        .BREAK_CLEAR_FLAG_ENABLE(break_clear_flag_enable), .BREAKPOINT_REQUEST(req), .BREAK_STATE(brk),
        .TAKE_SWI_NOW(software_interrupt_instruction), .BREAK_VECTOR(vec), .TIMER_HALT(halt),
        .WATCHDOG_DISABLE(wdd), .FLAG_CLEAR_ALLOW(fca), .IRQ(irq));
    abu_cpu_model cpu (.clk(clk), .rstn(rstn), .cmd(cmd), .tgt(tgt), .addr(ca),
        .fetch(cf), .last(cl), .return_from_interrupt_instruction(crti));
    task chk(input [8*5-1:0] nm, input [32:0] x, input [32:0] g);
        begin
            n_compared = n_compared + 1;
            if (x !== g) begin
                miscompares = miscompares + 1;
                $display("unexpected %0s exp %h got %h", nm, x, g);
            end
        end
    endtask
    task test_done;
        begin
            $display("compared %0d, mismatched %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // one apb transfer; a spare edge after release keeps drives apart
    task apb(input w, input [15:0] ix, input [7:0] d);
        begin
            psel <= 1'b1;
            pwr <= w;
            pa <= {14'h0, ix, 2'b00};
            pwd <= {24'h0, d};
            @(posedge clk);
            pen <= 1'b1;
            @(posedge clk);
            while (!prdy) @(posedge clk);
            psel <= 1'b0;
            pen <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd(input [15:0] ix, input [32:0] x);
        begin
            expq.push_back(x);
            apb(1'b0, ix, 8'h0);
        end
    endtask
    task cpu_do(input [1:0] c);
        begin
            cmd <= c;
            @(posedge clk);
            cmd <= 2'd0;
            repeat (2) @(posedge clk);
        end
    endtask
    // read results are matched against the oldest note
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (psel && pen && prdy && !pwr)
            chk("read", expq.pop_front(), {perr, prd});
        if (cyc == 3000) begin
            miscompares = miscompares + 1;
            test_done;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        tgt <= $random(seed);
        @(posedge clk);
        rd(`IDX_BREAK_ADDRESS_HIGH, 33'h0);
        rd(`IDX_BREAK_ADDRESS_LOW, 33'h0);
        rd(`IDX_BREAK_STATUS_CONTROL, 33'h0);
        rd(16'hfe0f, 33'h100000000);
        chk("vec", `VEC_BREAK_NORMAL, vec);
        apb(1'b1, `IDX_BREAK_ADDRESS_HIGH, tgt[15:8]);
        apb(1'b1, `IDX_BREAK_ADDRESS_LOW, tgt[7:0]);
        rd(`IDX_BREAK_ADDRESS_HIGH, tgt[15:8]);
        rd(`IDX_BREAK_ADDRESS_LOW, tgt[7:0]);
        cpu_do(2'd1);
        chk("req", 0, req);
        $display("map test done");
        apb(1'b1, `IDX_BREAK_STATUS_CONTROL, 8'hbf);
        rd(`IDX_BREAK_STATUS_CONTROL, 33'h80);
        cpu_do(2'd2);
        chk("req", 0, req);
        cpu_do(2'd1);
        chk("req", 1, req);
        chk("swi", 1, software_interrupt_instruction);
        @(posedge clk);
        chk("halt", 1, halt);
        chk("fca", 0, fca);
        hv <= 1'b1;
        break_clear_flag_enable <= 1'b1;
        repeat (8) @(posedge clk);
        chk("wdd", 1, wdd);
        chk("fca", 1, fca);
        rd(`IDX_BREAK_STATUS_CONTROL, 33'hc0);
        rd(`IDX_IRQ_STATUS, 33'h1);
        apb(1'b1, `IDX_IRQ_MASK, 8'h7);
        @(posedge clk);
        chk("irq", 1, irq);
        apb(1'b1, `IDX_IRQ_MASK, 8'h0);
        @(posedge clk);
        chk("irq", 0, irq);
        apb(1'b1, `IDX_IRQ_STATUS, 8'h7);
        rd(`IDX_IRQ_STATUS, 33'h0);
        apb(1'b1, `IDX_BREAK_STATUS_CONTROL, 8'h80);
        chk("req", 0, req);
        cpu_do(2'd3);
        @(posedge clk);
        chk("brk", 0, brk);
        $display("match test done");
        apb(1'b1, `IDX_BREAK_STATUS_CONTROL, 8'h40);
        chk("req", 1, req);
        mon <= 1'b1;
        repeat (2) @(posedge clk);
        chk("vec", `VEC_BREAK_MONITOR, vec);
        apb(1'b1, `IDX_BREAK_STATUS_CONTROL, 8'h00);
        cpu_do(2'd3);
        $display("soft break test done");
        test_done;
    end
endmodule // address_breakpoint_unit_tb

// ===== brk_consts.vh
`ifndef BRK_CONSTS_VH
`define BRK_CONSTS_VH
// ****************************************
// register map (printed offsets are not all multiples of four: index, byte addr = 4*index)
// ****************************************
`define IDX_BREAK_ADDRESS_HIGH 16'hfe0c
`define IDX_BREAK_ADDRESS_LOW 16'hfe0d
`define IDX_BREAK_STATUS_CONTROL 16'hfe0e
`define IDX_IRQ_STATUS 16'hfe10
`define IDX_IRQ_MASK 16'hfe11
`define IDX_CPU_STATUS 16'hfe12
// ****************************************
// field positions and reset values
// ****************************************
`define BIT_BREAK_ENABLE 7
`define BIT_BREAK_ACTIVE 6
`define BIT_IRQ_ADDR_MATCH 0
`define BIT_IRQ_SOFT_BREAK 1
`define BIT_IRQ_BREAK_END 2
`define RST_BYTE 8'h00
`define RST_IRQ 3'h0
// ****************************************
// break vectors
// ****************************************
`define VEC_BREAK_NORMAL 16'hfffc
`define VEC_BREAK_MONITOR 16'hfefc
`endif

// ===== brk_pin_sync.v
`timescale 1ns/10ps
// ****************************************
// three-stage synchroniser; output changes once stages two and three agree
// ****************************************
module brk_pin_sync (
    input wire REF_CLK,
    input wire RESETN,
    input wire din,
    output reg dout
);
    reg s1;
    reg s2;
    reg s3;
    // s1 feeds only s2 to keep metastability out of the compare
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule // brk_pin_sync
